// *** rtl/pirq_pkg.sv ***
// Package for the power, interrupt routing and auxiliary register bank.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
// What this block does
// - Second power-off delay is 500 ms times (six-bit code plus one).
// - Main-supply reset clears the delay register, giving the shortest 500 ms delay.
// - Delay starts only on a button press with power-off enable and delay option set.
// - Routing bit 0 low selects serial interrupt frame, high selects parallel pins.
// - Parallel mode disables BIOS buffer; serial pin is line 15, clock pin line 14.
// - Serial/parallel choice never affects SCI or SMI routing.
// - Routing bit 2 low sends SCI in the frame, high on a pin.
// - Routing bit 3 low makes SCI active low, high makes it active high.
// - Routing bit 4 low drives SCI push-pull, high open-drain.
// - Bits 6:5 put power event, SCI or line 9 on the shared pin.
// - With pin-select bit 5 set, the configured SCI interrupt number is ignored.
// - Shared pin driver follows its function: open-drain low, SCI bits, or push-pull high.
// - Routing bit 7 low puts SMI in frame slot 2, high on its pin.
// - SMI pin polarity and driver come from its pin configuration, default low open-drain.
// - Software may set forced disk-change bits but writing zero does nothing.
// - Step with drive select 1 clears bit 1; with drive select 0 clears bit 0.
// - Disk-changed status is selected forced bits ORed with the external input.
// - A set forced bit shows disk change while its drive is selected.
// - Forced bits 0 and 1 map to drives, bits 7:2 read zero, reset 0x03.
// - Read-only copy of floppy data-rate settings is kept.
// - Read-only copy of bits 7:6 and 3:0 of each UART FIFO control register is kept.
// - Battery reset clears the routing register to zero.
package pirq_pkg;
  localparam logic [7:0] OFS_DELAY   = 8'hB8;
  localparam logic [7:0] OFS_ROUTE   = 8'hC0;
  localparam logic [7:0] OFS_FORCE   = 8'hC1;
  localparam logic [7:0] OFS_RATE    = 8'hC2;
  localparam logic [7:0] OFS_FIFO1   = 8'hC3;
  localparam logic [7:0] OFS_FIFO2   = 8'hC4;
  localparam logic [7:0] OFS_PWRCTL  = 8'hC8;
  localparam logic [7:0] OFS_PWRSTAT = 8'hCC;

  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_FORCE = 8'h03;
  localparam logic [7:0] RST_COPY  = 8'h00;
  localparam logic [7:0] RST_PWR   = 8'h00;

  localparam int DELAY_W     = 6;
  localparam int FORCE_MASK  = 8'h03;
  localparam int BIT_PARALLEL = 0;
  localparam int BIT_SCI_PIN  = 2;
  localparam int BIT_SCI_POL  = 3;
  localparam int BIT_SCI_OD   = 4;
  localparam int BIT_SHARE_LO = 5;
  localparam int BIT_SMI_PIN  = 7;
  localparam int BIT_PWR_EN   = 0;
  localparam int BIT_OFF_DELAY_OPTION = 1;

  localparam logic [1:0] SHARE_PME  = 2'h0;
  localparam logic [1:0] SHARE_SCI  = 2'h1;
  localparam logic [1:0] SHARE_IRQ9 = 2'h2;

  localparam int  CLK_HZ       = 10_000_000;
  localparam int  STEP_MS      = 500;
  localparam int  STEP_CYCLES  = (CLK_HZ / 1000) * STEP_MS;

  typedef enum logic [1:0] {PIRQ_IDLE, PIRQ_RUN, PIRQ_DONE} pirq_state_t;

  typedef struct packed {
    logic       drive_select_zero_low;
    logic       drive_select_one_low;
    logic       head_step_low;
    logic       disk_change_in_low;
  } pirq_fdd_t;

  typedef struct packed {
    logic       wr_rate;
    logic       wr_fifo1;
    logic       wr_fifo2;
    logic [7:0] data;
  } pirq_orig_t;
endpackage : pirq_pkg

// *** rtl/pirq_regs.sv ***
// Register bank for power-off delay, interrupt routing and floppy/UART copies.
// Assumes synchronous inputs, one 10 MHz clock and a classic Wishbone master.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module pirq_regs #(
  parameter int STEP_CYCLES = pirq_pkg::STEP_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               vbat_rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire pirq_pkg::pirq_fdd_t  fdd_i,
  input  wire pirq_pkg::pirq_orig_t orig_i,
  input  wire logic               button_i,
  input  wire logic               sci_i,
  input  wire logic               smi_i,
  input  wire logic               pme_i,
  input  wire logic               irq9_i,
  input  wire logic               smi_pin_invert_i,
  input  wire logic               smi_pin_push_pull_i,
  output logic                    disk_changed_status_o,
  output logic                    power_off_o,
  output logic                    parallel_irq_o,
  output logic                    bios_buffer_en_o,
  output logic                    sci_in_frame_o,
  output logic                    smi_in_frame_o,
  output logic                    sci_cfg_irq_ignore_o,
  output logic                    sci_pin_o,
  output logic                    sci_pin_oe_n_o,
  output logic                    share_pin_o,
  output logic                    share_pin_oe_n_o,
  output logic                    system_mgmt_irq_pin_o,
  output logic                    system_mgmt_irq_pin_oe_n_o
);
  logic [7:0]  delay_q;
  logic [7:0]  route_q;
  logic [7:0]  force_q;
  logic [7:0]  rate_q;
  logic [7:0]  fifo1_q;
  logic [7:0]  fifo2_q;
  logic [1:0]  pwrctl_q;
  logic [23:0] tick_q;
  logic [5:0]  steps_q;
  logic        wr_req;
  logic        rd_req;
  logic        wr_lo;
  logic [7:0]  wd;
  logic [7:0]  rd_d;
  logic        sci_lvl;
  logic [1:0]  share_sel;
  pirq_pkg::pirq_state_t state_q;

  // Ack answers one cycle after the strobe and drops the cycle after
  assign wr_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign wr_lo  = wr_req && wb_sel_i[0];
  assign wd     = wb_dat_i[7:0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_comb
  begin
    case (wb_adr_i)
      pirq_pkg::OFS_DELAY:   rd_d = delay_q;
      pirq_pkg::OFS_ROUTE:   rd_d = route_q;
      pirq_pkg::OFS_FORCE:   rd_d = force_q & 8'(pirq_pkg::FORCE_MASK);
      pirq_pkg::OFS_RATE:    rd_d = rate_q;
      pirq_pkg::OFS_FIFO1:   rd_d = fifo1_q;
      pirq_pkg::OFS_FIFO2:   rd_d = fifo2_q;
      pirq_pkg::OFS_PWRCTL:  rd_d = {6'h00, pwrctl_q};
      pirq_pkg::OFS_PWRSTAT: rd_d = {6'h00, state_q == pirq_pkg::PIRQ_RUN, power_off_o};
      default:               rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd_req)
      wb_dat_o <= {24'h00_0000, rd_d};
  end

  // Delay register lives on the main-supply reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      delay_q <= pirq_pkg::RST_DELAY;
    else if (wr_lo && wb_adr_i == pirq_pkg::OFS_DELAY)
      delay_q <= {2'h0, wd[pirq_pkg::DELAY_W-1:0]};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwrctl_q <= pirq_pkg::RST_PWR[1:0];
    else if (wr_lo && wb_adr_i == pirq_pkg::OFS_PWRCTL)
      pwrctl_q <= wd[1:0];
  end

  // Routing survives main-supply reset; only the battery reset clears it
  always_ff @(posedge clk_i)
  begin
    if (vbat_rst_i)
      route_q <= pirq_pkg::RST_ROUTE;
    else if (wr_lo && wb_adr_i == pirq_pkg::OFS_ROUTE)
      route_q <= {wd[7:2], 1'b0, wd[0]};
  end

  // Hardware clear beats software set only where a step hits the drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      force_q <= pirq_pkg::RST_FORCE;
    else
    begin
      if (wr_lo && wb_adr_i == pirq_pkg::OFS_FORCE)
        force_q[1:0] <= force_q[1:0] | wd[1:0];
      if (!fdd_i.head_step_low && !fdd_i.drive_select_one_low)
        force_q[1] <= 1'b0;
      if (!fdd_i.head_step_low && !fdd_i.drive_select_zero_low)
        force_q[0] <= 1'b0;
      force_q[7:2] <= 6'h00;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      disk_changed_status_o <= 1'b0;
    else
      disk_changed_status_o <= (!fdd_i.drive_select_zero_low && force_q[0])
                             || (!fdd_i.drive_select_one_low && force_q[1])
                             || !fdd_i.disk_change_in_low;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_q  <= pirq_pkg::RST_COPY;
      fifo1_q <= pirq_pkg::RST_COPY;
      fifo2_q <= pirq_pkg::RST_COPY;
    end
    else
    begin
      if (orig_i.wr_rate)
        rate_q <= orig_i.data;
      if (orig_i.wr_fifo1)
        fifo1_q <= {orig_i.data[7:6], 2'h0, orig_i.data[3:0]};
      if (orig_i.wr_fifo2)
        fifo2_q <= {orig_i.data[7:6], 2'h0, orig_i.data[3:0]};
    end
  end

  // Step tick counts 500 ms; steps run code+1 ticks, so jitter stays under one tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= pirq_pkg::PIRQ_IDLE;
      tick_q  <= 24'h00_0000;
      steps_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        pirq_pkg::PIRQ_IDLE:
          if (button_i && pwrctl_q[pirq_pkg::BIT_PWR_EN]
              && pwrctl_q[pirq_pkg::BIT_OFF_DELAY_OPTION])
          begin
            state_q <= pirq_pkg::PIRQ_RUN;
            tick_q  <= 24'h00_0000;
            steps_q <= delay_q[5:0];
          end
        pirq_pkg::PIRQ_RUN:
          if (tick_q == 24'(STEP_CYCLES - 1))
          begin
            tick_q <= 24'h00_0000;
            if (steps_q == 6'h00)
              state_q <= pirq_pkg::PIRQ_DONE;
            else
              steps_q <= steps_q - 6'h01;
          end
          else
            tick_q <= tick_q + 24'h00_0001;
        pirq_pkg::PIRQ_DONE:
          if (!pwrctl_q[pirq_pkg::BIT_PWR_EN])
            state_q <= pirq_pkg::PIRQ_IDLE;
        default:
          state_q <= pirq_pkg::PIRQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      power_off_o <= 1'b0;
    else
      power_off_o <= state_q == pirq_pkg::PIRQ_DONE;
  end

  // Interrupt routing
  assign share_sel = route_q[6:5];
  assign sci_lvl   = route_q[pirq_pkg::BIT_SCI_POL] ? sci_i : !sci_i;

  always_ff @(posedge clk_i)
  begin
    if (vbat_rst_i)
    begin
      parallel_irq_o       <= 1'b0;
      bios_buffer_en_o     <= 1'b1;
      sci_in_frame_o       <= 1'b0;
      smi_in_frame_o       <= 1'b0;
      sci_cfg_irq_ignore_o <= 1'b0;
    end
    else
    begin
      parallel_irq_o       <= route_q[pirq_pkg::BIT_PARALLEL];
      bios_buffer_en_o     <= !route_q[pirq_pkg::BIT_PARALLEL];
      // Frame placement ignores bit 0 on purpose
      sci_in_frame_o       <= sci_i && !route_q[pirq_pkg::BIT_SCI_PIN];
      smi_in_frame_o       <= smi_i && !route_q[pirq_pkg::BIT_SMI_PIN];
      sci_cfg_irq_ignore_o <= route_q[pirq_pkg::BIT_SHARE_LO];
    end
  end

  // Open-drain: drive low with oe_n low, release high with oe_n high
  always_ff @(posedge clk_i)
  begin
    if (vbat_rst_i)
    begin
      sci_pin_o      <= 1'b1;
      sci_pin_oe_n_o <= 1'b1;
    end
    else if (!route_q[pirq_pkg::BIT_SCI_PIN])
    begin
      sci_pin_o      <= 1'b1;
      sci_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      sci_pin_o      <= sci_lvl;
      sci_pin_oe_n_o <= route_q[pirq_pkg::BIT_SCI_OD] && sci_lvl;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (vbat_rst_i)
    begin
      share_pin_o      <= 1'b1;
      share_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      case (share_sel)
        pirq_pkg::SHARE_PME:
        begin
          share_pin_o      <= !pme_i;
          share_pin_oe_n_o <= !pme_i;
        end
        pirq_pkg::SHARE_SCI:
        begin
          share_pin_o      <= sci_lvl;
          share_pin_oe_n_o <= route_q[pirq_pkg::BIT_SCI_OD] && sci_lvl;
        end
        pirq_pkg::SHARE_IRQ9:
        begin
          share_pin_o      <= irq9_i;
          share_pin_oe_n_o <= 1'b0;
        end
        default:
        begin
          share_pin_o      <= 1'b1;
          share_pin_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // SMI pin style comes from its pin configuration inputs
  always_ff @(posedge clk_i)
  begin
    if (vbat_rst_i)
    begin
      system_mgmt_irq_pin_o      <= 1'b1;
      system_mgmt_irq_pin_oe_n_o <= 1'b1;
    end
    else if (!route_q[pirq_pkg::BIT_SMI_PIN])
    begin
      system_mgmt_irq_pin_o      <= 1'b1;
      system_mgmt_irq_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      system_mgmt_irq_pin_o      <= smi_pin_invert_i ? smi_i : !smi_i;
      system_mgmt_irq_pin_oe_n_o <= !smi_pin_push_pull_i
                                 && (smi_pin_invert_i ? smi_i : !smi_i);
    end
  end
endmodule : pirq_regs
`default_nettype wire

// *** tb/pirq_line_model.sv ***
// Far-side interrupt lines as the system interrupt controller sees them.
// Assumes pull-ups on every line, so a released pin reads high.
`timescale 1ns/100ps
`default_nettype none
module pirq_line_model (
  input  wire logic sci_i,
  input  wire logic sci_oe_n_i,
  input  wire logic shr_i,
  input  wire logic shr_oe_n_i,
  input  wire logic smi_i,
  input  wire logic smi_oe_n_i,
  output logic      sci_line_o,
  output logic      shr_line_o,
  output logic      smi_line_o
);
  // Pull-up wins only when the device lets go of the pin
  assign sci_line_o = sci_oe_n_i ? 1'b1 : sci_i;
  assign shr_line_o = shr_oe_n_i ? 1'b1 : shr_i;
  assign smi_line_o = smi_oe_n_i ? 1'b1 : smi_i;
endmodule : pirq_line_model
`default_nettype wire

// *** tb/pirq_regs_chk.sv ***
// Checker for the register bank ports.
// Assumes it is bound into every instance of pirq_regs.
`timescale 1ns/100ps
`default_nettype none
module pirq_regs_chk (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                vbat_rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire pirq_pkg::pirq_fdd_t fdd_i,
  input wire logic                parallel_irq_o,
  input wire logic                bios_buffer_en_o,
  input wire logic                disk_changed_status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || vbat_rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (req |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_force_rsvd: assert property (req && !wb_we_i && wb_adr_i == pirq_pkg::OFS_FORCE
    |=> wb_dat_o[7:2] == 6'h0)
    else $error("forced change reserved bits set");
  a_bios_off: assert property (parallel_irq_o |-> !bios_buffer_en_o)
    else $error("buffer on in parallel mode");
  a_par_follow: assert property (req && wb_we_i && wb_sel_i[0]
    && wb_adr_i == pirq_pkg::OFS_ROUTE |-> ##2 parallel_irq_o == $past(wb_dat_i[0], 2))
    else $error("parallel select not following register");
  a_chg_ext: assert property (!rst_i && $past(!rst_i && !fdd_i.disk_change_in_low)
    |-> disk_changed_status_o)
    else $error("disk change input not shown");
endmodule : pirq_regs_chk
bind pirq_regs pirq_regs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .vbat_rst_i(vbat_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fdd_i(fdd_i), .parallel_irq_o(parallel_irq_o), .bios_buffer_en_o(bios_buffer_en_o),
  .disk_changed_status_o(disk_changed_status_o));
`default_nettype wire

// *** tb/pirq_regs_tb.sv ***
// Self-checking bench for the register bank.
// Assumes a short delay step so the timer finishes quickly.
`timescale 1ns/100ps
`default_nettype none
module pirq_regs_tb;
  localparam int STEP = 10;
  logic clk_i = 0, rst_i = 1, vb = 1, cyc = 0, stb = 0, we = 0, btn = 0;
  logic sci = 0, smi = 0, pme = 0, irq9 = 0, ack, sts, poff, par, bios, ign;
  logic sinv = 0, spp = 0, sif, mif;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00, r;
  logic [31:0] wdat = 32'h0, rdat;
  logic sp, sp_n, hp, hp_n, mp, mp_n, sl, hl, ml;
  pirq_pkg::pirq_fdd_t fdd = 4'hF;
  pirq_pkg::pirq_orig_t org = 11'h0;
  int fails = 0, compares = 0;
  pirq_regs #(.STEP_CYCLES(STEP)) u_pirq_regs (.clk_i(clk_i), .rst_i(rst_i), .vbat_rst_i(vb),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fdd_i(fdd), .orig_i(org),
    .button_i(btn), .sci_i(sci), .smi_i(smi), .pme_i(pme), .irq9_i(irq9),
    .smi_pin_invert_i(sinv), .smi_pin_push_pull_i(spp), .disk_changed_status_o(sts),
    .power_off_o(poff), .parallel_irq_o(par), .bios_buffer_en_o(bios), .sci_in_frame_o(sif),
    .smi_in_frame_o(mif), .sci_cfg_irq_ignore_o(ign), .sci_pin_o(sp), .sci_pin_oe_n_o(sp_n),
    .share_pin_o(hp), .share_pin_oe_n_o(hp_n), .system_mgmt_irq_pin_o(mp),
    .system_mgmt_irq_pin_oe_n_o(mp_n));
  pirq_line_model u_pirq_line_model (.sci_i(sp), .sci_oe_n_i(sp_n), .shr_i(hp),
    .shr_oe_n_i(hp_n), .smi_i(mp), .smi_oe_n_i(mp_n), .sci_line_o(sl), .shr_line_o(hl),
    .smi_line_o(ml));
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc_n
  // Classic cycle: hold everything until ack is seen, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      close_out();
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    cmp("read", e, r);
  endtask : rd
  task automatic t_reset;
    rd(8'hB8, 8'h00);
    rd(8'hC0, 8'h00);
    rd(8'hC1, 8'h03);
    rd(8'hF0, 8'h00);
    cmp("bios", 1, bios);
    $display("reset test done");
  endtask : t_reset
  task automatic t_force;
    fdd.drive_select_zero_low <= 0;
    cyc_n(3);
    cmp("sts", 1, sts);
    fdd.head_step_low <= 0;
    cyc_n(1);
    fdd.head_step_low <= 1;
    cyc_n(3);
    rd(8'hC1, 8'h02);
    cmp("sts", 0, sts);
    wb(1'b1, 8'hC1, 8'h00);
    rd(8'hC1, 8'h02);
    fdd <= 4'h9;
    cyc_n(3);
    rd(8'hC1, 8'h00);
    fdd <= 4'hE;
    cyc_n(3);
    cmp("sts", 1, sts);
    fdd <= 4'hF;
    wb(1'b1, 8'hC1, 8'h01);
    rd(8'hC1, 8'h01);
    wb(1'b1, 8'hC1, 8'h02);
    fdd <= 4'hB;
    cyc_n(3);
    cmp("sts", 8'h01, sts);
    fdd <= 4'hF;
    cyc_n(1);
    $display("forced change test done");
  endtask : t_force
  task automatic rt(input logic [7:0] v);
    wb(1'b1, 8'hC0, v);
    cyc_n(3);
  endtask : rt
  task automatic t_route;
    sci <= 1'b1;
    smi <= 1'b1;
    pme <= 1'b1;
    irq9 <= 1'b1;
    rt(8'h01);
    cmp("par", 1, par);
    cmp("bios", 0, bios);
    cmp("sif", 8'h01, sif);
    cmp("mif", 8'h01, mif);
    rt(8'hFF);
    rd(8'hC0, 8'hFD);
    cmp("ign", 1, ign);
    rt(8'h0C);
    cmp("sci", 8'h02, {sp, sp_n});
    cmp("sif", 8'h00, sif);
    rt(8'h04);
    cmp("sci", 0, sl);
    rt(8'h1C);
    cmp("sci", 8'h03, {sp, sp_n});
    sci <= 1'b0;
    cyc_n(3);
    cmp("sci", 8'h00, {sp, sp_n});
    sci <= 1'b1;
    rt(8'h20);
    cmp("shr", 8'h00, hl);
    cmp("ign", 8'h01, ign);
    rt(8'h40);
    cmp("irq9", 8'h02, {hp, hp_n});
    rt(8'h80);
    cmp("smi", 0, ml);
    cmp("mif", 8'h00, mif);
    sinv <= 1'b1;
    spp <= 1'b1;
    cyc_n(3);
    cmp("smi", 8'h02, {mp, mp_n});
    sinv <= 1'b0;
    spp <= 1'b0;
    smi <= 1'b0;
    cyc_n(3);
    cmp("smi", 8'h01, ml);
    smi <= 1'b1;
    rt(8'h00);
    cmp("pme", 0, hl);
    cmp("par", 0, par);
    cmp("mif", 8'h01, mif);
    $display("routing test done");
  endtask : t_route
  task automatic t_copy;
    org <= {3'b100, 8'hC3};
    cyc_n(1);
    org <= {3'b010, 8'hFF};
    cyc_n(1);
    org <= {3'b001, 8'h81};
    cyc_n(1);
    org <= 11'h0;
    cyc_n(1);
    rd(8'hC2, 8'hC3);
    rd(8'hC3, 8'hCF);
    rd(8'hC4, 8'h81);
    $display("copy test done");
  endtask : t_copy
  task automatic t_delay;
    int n;
    n = 0;
    wb(1'b1, 8'hB8, 8'h02);
    wb(1'b1, 8'hC8, 8'h01);
    btn <= 1;
    cyc_n(1);
    btn <= 0;
    cyc_n(60);
    cmp("poff", 0, poff);
    wb(1'b1, 8'hC8, 8'h03);
    btn <= 1;
    cyc_n(1);
    btn <= 0;
    while (poff !== 1'b1 && n < 60)
    begin
      cyc_n(1);
      n++;
    end
    if (n >= 60)
    begin
      fails++;
      close_out();
    end
    cmp("delay", 1, n >= 29 && n <= 34);
    rd(8'hCC, 8'h01);
    wb(1'b1, 8'hC8, 8'h00);
    cyc_n(3);
    cmp("poff", 0, poff);
    $display("delay test done");
  endtask : t_delay
  // Main-supply reset must spare routing; only the battery reset clears it
  task automatic t_mid_reset;
    wb(1'b1, 8'hC0, 8'h81);
    wb(1'b1, 8'hB8, 8'hFF);
    sel <= 4'hE;
    wb(1'b1, 8'hB8, 8'h05);
    sel <= 4'hF;
    rd(8'hB8, 8'h3F);
    rst_i <= 1'b1;
    cyc_n(2);
    rst_i <= 1'b0;
    cyc_n(1);
    rd(8'hB8, 8'h00);
    rd(8'hC0, 8'h81);
    rd(8'hC1, 8'h03);
    cmp("par", 8'h01, par);
    vb <= 1'b1;
    cyc_n(2);
    vb <= 1'b0;
    cyc_n(1);
    rd(8'hC0, 8'h00);
    cmp("bios", 8'h01, bios);
    $display("mid reset test done");
  endtask : t_mid_reset
  initial
  begin
    cyc_n(8);
    rst_i <= 0;
    vb <= 0;
    cyc_n(1);
    t_reset();
    t_force();
    t_route();
    t_copy();
    t_delay();
    t_mid_reset();
    close_out();
  end
endmodule : pirq_regs_tb
`default_nettype wire
